// >>> verilog/dic_pkg.sv
// package for the digital input conditioning block
// assumes a 125 MHz aclk and an AXI4-Lite register port
package dic_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_SPECIAL_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_INVERSION = 8'h04;
  localparam logic [7:0] ADDR_FORCE_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_FORCE_VALUE = 8'h0C;
  localparam logic [7:0] ADDR_RAW_LEVELS = 8'h10;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h14;
  localparam logic [7:0] ADDR_DIFFERENTIAL = 8'h18;
  localparam logic [7:0] ADDR_SUMMARY = 8'h1C;

  // ==========================================================
  // field layout and reset values
  localparam int LEVEL_LSB = 16;
  localparam int SPECIAL_COUNT = 3;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // timing
  localparam int CLOCK_HZ = 125000000;
  localparam int SAMPLE_PERIOD_US = 1000;
  localparam int SAMPLE_CYCLES = CLOCK_HZ / 1000000 * SAMPLE_PERIOD_US;

  typedef struct packed {
    logic [31:0] special_enable;
    logic [31:0] inversion;
    logic [31:0] force_enable;
    logic [31:0] force_value;
    logic [31:0] threshold;
    logic differential;
  } dic_config_type;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_RESP = 3'b010,
    RD_UNUSED = 3'b100
  } dic_read_state_type;

endpackage

// >>> verilog/dic_top.sv
// digital input conditioning: sample, force, invert, gate, summarise
// assumes pins are asynchronous to aclk and software uses AXI4-Lite
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module dic_top #(
  parameter int NUM_INPUTS = 6,
  parameter int SAMPLE_CYCLES = dic_pkg::SAMPLE_CYCLES
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [NUM_INPUTS-1:0] input_pins, // asynchronous switch inputs
  output logic [NUM_INPUTS-1:0] threshold_24v, // per-input 24 V threshold select
  output logic differential_mode, // all inputs differential
  output logic [31:0] summary_out, // conditioned summary word
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  initial
  begin
    if (NUM_INPUTS < 3 || NUM_INPUTS > 16)
      $error("NUM_INPUTS must be 3 to 16");
    if (SAMPLE_CYCLES < 2)
      $error("SAMPLE_CYCLES must be at least 2");
  end

  // ==========================================================
  // pin synchroniser
  logic [NUM_INPUTS-1:0] sync1_reg;
  logic [NUM_INPUTS-1:0] sync2_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= input_pins;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // millisecond tick
  logic [31:0] tick_count_reg;
  logic tick;

  assign tick = (tick_count_reg == 32'(SAMPLE_CYCLES - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_count_reg <= 32'h0000_0000;
    else if (tick)
      tick_count_reg <= 32'h0000_0000;
    else
      tick_count_reg <= tick_count_reg + 32'h0000_0001;
  end

  // ==========================================================
  // configuration registers and write channel
  dic_pkg::dic_config_type cfg_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic write_hit;

  // address and data are taken independently; the write fires once both are held
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign write_hit = (awaddr_reg == dic_pkg::ADDR_SPECIAL_ENABLE)
    || (awaddr_reg == dic_pkg::ADDR_INVERSION)
    || (awaddr_reg == dic_pkg::ADDR_FORCE_ENABLE)
    || (awaddr_reg == dic_pkg::ADDR_FORCE_VALUE)
    || (awaddr_reg == dic_pkg::ADDR_THRESHOLD)
    || (awaddr_reg == dic_pkg::ADDR_DIFFERENTIAL);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] result;
    result = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        result[i*8 +: 8] = data[i*8 +: 8];
    return result;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= dic_pkg::RESET_WORD;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dic_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= write_hit ? dic_pkg::RESP_OKAY : dic_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_reg <= '0;
    else if (do_write)
    begin
      case (awaddr_reg)
        dic_pkg::ADDR_SPECIAL_ENABLE:
          cfg_reg.special_enable <= merge(cfg_reg.special_enable, wdata_reg, wstrb_reg);
        dic_pkg::ADDR_INVERSION:
          cfg_reg.inversion <= merge(cfg_reg.inversion, wdata_reg, wstrb_reg);
        dic_pkg::ADDR_FORCE_ENABLE:
          cfg_reg.force_enable <= merge(cfg_reg.force_enable, wdata_reg, wstrb_reg);
        dic_pkg::ADDR_FORCE_VALUE:
          cfg_reg.force_value <= merge(cfg_reg.force_value, wdata_reg, wstrb_reg);
        dic_pkg::ADDR_THRESHOLD:
          cfg_reg.threshold <= merge(cfg_reg.threshold, wdata_reg, wstrb_reg);
        dic_pkg::ADDR_DIFFERENTIAL:
          if (wstrb_reg[0])
            cfg_reg.differential <= wdata_reg[0];
        default:
          cfg_reg <= cfg_reg;
      endcase
    end
  end

  // analog front end selects are plain outputs from the config flops
  assign threshold_24v = cfg_reg.threshold[NUM_INPUTS-1:0];
  assign differential_mode = cfg_reg.differential;

  // ==========================================================
  // conditioning pipeline, one update per tick
  logic [NUM_INPUTS-1:0] raw_reg;
  logic [31:0] summary_reg;
  logic [NUM_INPUTS-1:0] forced;
  logic [NUM_INPUTS-1:0] conditioned;
  logic [31:0] summary_next;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      raw_reg <= '0;
    else if (tick)
      raw_reg <= sync2_reg;
  end

  // force first, then invert, so an inverted input also inverts its forced value
  assign forced = (cfg_reg.force_enable[NUM_INPUTS-1:0] & cfg_reg.force_value[NUM_INPUTS-1:0])
    | (~cfg_reg.force_enable[NUM_INPUTS-1:0] & sync2_reg);
  assign conditioned = forced ^ cfg_reg.inversion[NUM_INPUTS-1:0];

  always_comb
  begin
    summary_next = dic_pkg::RESET_WORD;
    // special bits only exist for the first three inputs
    for (int i = 0; i < dic_pkg::SPECIAL_COUNT; i++)
      summary_next[i] = conditioned[i] & cfg_reg.special_enable[i];
    // level bits never see the special-function enable
    for (int i = 0; i < NUM_INPUTS; i++)
      summary_next[dic_pkg::LEVEL_LSB + i] = conditioned[i];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      summary_reg <= dic_pkg::RESET_WORD;
    else if (tick)
      summary_reg <= summary_next;
  end

  assign summary_out = summary_reg;

  // ==========================================================
  // read channel
  dic_pkg::dic_read_state_type rd_state_reg;
  logic [31:0] read_word;
  logic read_hit;

  assign s_axi_arready = (rd_state_reg == dic_pkg::RD_IDLE);
  assign s_axi_rvalid = (rd_state_reg == dic_pkg::RD_RESP);

  always_comb
  begin
    read_word = dic_pkg::RESET_WORD;
    read_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      dic_pkg::ADDR_SPECIAL_ENABLE: read_word = cfg_reg.special_enable;
      dic_pkg::ADDR_INVERSION: read_word = cfg_reg.inversion;
      dic_pkg::ADDR_FORCE_ENABLE: read_word = cfg_reg.force_enable;
      dic_pkg::ADDR_FORCE_VALUE: read_word = cfg_reg.force_value;
      dic_pkg::ADDR_RAW_LEVELS: read_word[NUM_INPUTS-1:0] = raw_reg;
      dic_pkg::ADDR_THRESHOLD: read_word = cfg_reg.threshold;
      dic_pkg::ADDR_DIFFERENTIAL: read_word[0] = cfg_reg.differential;
      dic_pkg::ADDR_SUMMARY: read_word = summary_reg;
      default: read_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_reg <= dic_pkg::RD_IDLE;
      s_axi_rdata <= dic_pkg::RESET_WORD;
      s_axi_rresp <= dic_pkg::RESP_OKAY;
    end
    else
    begin
      case (rd_state_reg)
        dic_pkg::RD_IDLE:
          if (s_axi_arvalid)
          begin
            rd_state_reg <= dic_pkg::RD_RESP;
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_hit ? dic_pkg::RESP_OKAY : dic_pkg::RESP_SLVERR;
          end
        dic_pkg::RD_RESP:
          if (s_axi_rready)
            rd_state_reg <= dic_pkg::RD_IDLE;
        default:
          rd_state_reg <= dic_pkg::RD_IDLE;
      endcase
    end
  end

  // ==========================================================
  // checks
  sequence s_tick_seen;
    tick;
  endsequence

  // gap since the last tick, counted apart from the tick counter so a bad compare shows up
  logic [31:0] tick_gap_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_gap_reg <= 32'h0000_0001;
    else if (tick)
      tick_gap_reg <= 32'h0000_0001;
    else
      tick_gap_reg <= tick_gap_reg + 32'h0000_0001;
  end

  property p_tick_period;
    @(posedge aclk) disable iff (!aresetn)
      tick |-> tick_gap_reg == 32'(SAMPLE_CYCLES);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("sample period wrong");

  property p_tick_due;
    @(posedge aclk) disable iff (!aresetn)
      !tick |-> tick_gap_reg < 32'(SAMPLE_CYCLES);
  endproperty
  a_tick_due: assert property (p_tick_due) else $error("sample period overrun");

  property p_hold_between_ticks;
    @(posedge aclk) disable iff (!aresetn)
      !tick |=> $stable(summary_reg) || $past(!aresetn);
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks)
    else $error("summary moved");

  property p_special_gated;
    @(posedge aclk) disable iff (!aresetn)
      s_tick_seen ##0 !cfg_reg.special_enable[0] |=> !summary_reg[0];
  endproperty
  a_special_gated: assert property (p_special_gated)
    else $error("disabled special bit set");

  property p_level_ungated;
    @(posedge aclk) disable iff (!aresetn)
      s_tick_seen |=> summary_reg[16] == $past(conditioned[0]);
  endproperty
  a_level_ungated: assert property (p_level_ungated) else $error("bit 16 wrong");

  property p_upper_clear;
    @(posedge aclk) disable iff (!aresetn)
      1'b1 |-> summary_reg[15:dic_pkg::SPECIAL_COUNT] == '0;
  endproperty
  a_upper_clear: assert property (p_upper_clear) else $error("unused special bits set");

  property p_force_invert;
    @(posedge aclk) disable iff (!aresetn)
      s_tick_seen ##0 cfg_reg.force_enable[1]
        |=> summary_reg[17] == ($past(cfg_reg.force_value[1]) ^ $past(cfg_reg.inversion[1]));
  endproperty
  a_force_invert: assert property (p_force_invert) else $error("forced value wrong");

  property p_raw_unforced;
    @(posedge aclk) disable iff (!aresetn)
      s_tick_seen |=> raw_reg == $past(sync2_reg);
  endproperty
  a_raw_unforced: assert property (p_raw_unforced) else $error("raw value wrong");

  property p_diff_out;
    @(posedge aclk) disable iff (!aresetn)
      differential_mode == cfg_reg.differential
        && threshold_24v == cfg_reg.threshold[NUM_INPUTS-1:0];
  endproperty
  a_diff_out: assert property (p_diff_out) else $error("front end select wrong");

  property p_raw_hold;
    @(posedge aclk) disable iff (!aresetn)
      !tick |=> $stable(raw_reg);
  endproperty
  a_raw_hold: assert property (p_raw_hold) else $error("raw value moved");

  property p_special_passes;
    @(posedge aclk) disable iff (!aresetn)
      s_tick_seen ##0 cfg_reg.special_enable[2] |=> summary_reg[2] == $past(conditioned[2]);
  endproperty
  a_special_passes: assert property (p_special_passes)
    else $error("enabled special bit wrong");

  property p_invert_pin;
    @(posedge aclk) disable iff (!aresetn)
      s_tick_seen ##0 !cfg_reg.force_enable[0]
        |=> summary_reg[16] == ($past(sync2_reg[0]) ^ $past(cfg_reg.inversion[0]));
  endproperty
  a_invert_pin: assert property (p_invert_pin) else $error("inverted level wrong");

endmodule

`default_nettype wire

// >>> tb/dic_switch_model.sv
// switch model: drives the six input pins of the conditioning block
// assumes the bench sets level and chatter just after rising edges
`timescale 1ns/10ps
`default_nettype none

module dic_switch_model #(
  parameter int N = 6
) (
  input wire logic aclk, // bench clock
  input wire logic [N-1:0] level, // steady switch levels
  input wire logic chatter, // contact bounce on every cycle
  output logic [N-1:0] pins // to the block
);
  initial pins = '0;

  // bounce gives a new pattern each cycle, so a stale sample cannot pass
  always @(posedge aclk)
    pins <= chatter ? N'($urandom) : level;
endmodule

`default_nettype wire

// >>> tb/digital_input_conditioning_tb.sv
// self-checking bench: random settings against a shadow model of the block
// assumes dic_switch_model on the pins and a tick shortened to SC cycles
`timescale 1ns/10ps
`default_nettype none

module digital_input_conditioning_tb;
  localparam int SC = 8;
  logic aclk, aresetn, chatter, diff, ok;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [5:0] level, pins, thr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, summary, rd, prev, e;
  logic [1:0] bresp, rresp, resp;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  int cfg[8];
  int gap;

  dic_switch_model #(.N(6)) i_sw (.aclk(aclk), .level(level), .chatter(chatter), .pins(pins));

  dic_top #(.NUM_INPUTS(6), .SAMPLE_CYCLES(SC)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .input_pins(pins), .threshold_24v(thr),
    .differential_mode(diff), .summary_out(summary),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ==========
  // checking
  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles > 12000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  // forcing first, then inversion, then gating of the special bits
  function automatic logic [31:0] exp_sum(input logic [5:0] p);
    logic [5:0] c;
    c = ((6'(cfg[2]) & 6'(cfg[3])) | (~6'(cfg[2]) & p)) ^ 6'(cfg[1]);
    return {10'h0, c, 13'h0, c[2:0] & 3'(cfg[0])};
  endfunction

  // ==========
  // register bus; ready and answers are looked at mid-cycle, where they are settled
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tk;
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tk = 1'b0;
    for (n = 0; n < 200 && !tk; n++)
    begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tk = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tk) bready <= 1'b0;
    end
    if (!tk) miscompares++;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tk;
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tk = 1'b0;
    for (n = 0; n < 200 && !tk; n++)
    begin
      @(negedge aclk);
      ta = arvalid & arready;
      tk = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tk) rready <= 1'b0;
    end
    if (!tk) miscompares++;
  endtask

  task automatic set_cfg(input int i, input int v);
    axi_write(8'(i * 4), v, resp);
    check({30'h0, resp}, {30'h0, dic_pkg::RESP_OKAY});
    cfg[i] = v;
  endtask

  // ==========
  // scenarios
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, chatter} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    level = '0;
    aresetn = 1'b0;
    cfg = '{default: 0};
    rd = $urandom(73080);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      axi_read(8'(i * 4), rd, resp);
      check(rd, 32'h0);
    end
    repeat (24)
    begin
      for (int i = 0; i < 7; i++)
        if (i != 4) set_cfg(i, $urandom);
      level <= 6'($urandom);
      repeat (2 * SC + 4) @(posedge aclk);
      e = exp_sum(level);
      check(summary, e);
      check({16'h0, summary[31:16]}, {16'h0, e[31:16]});
      axi_read(dic_pkg::ADDR_SUMMARY, rd, resp);
      check(rd, e);
      axi_read(dic_pkg::ADDR_RAW_LEVELS, rd, resp);
      check(rd, {26'h0, level});
      check({26'h0, thr}, 32'(cfg[5]) & 32'h3F);
      check({31'h0, diff}, 32'(cfg[6]) & 32'h1);
      for (int i = 0; i < 4; i++)
      begin
        axi_read(8'(i * 4), rd, resp);
        check(rd, 32'(cfg[i]));
      end
    end
    // read-only and unmapped places refuse writes and keep their contents
    for (int k = 0; k < 3; k++)
    begin
      axi_write(k == 0 ? dic_pkg::ADDR_RAW_LEVELS : (k == 1 ? dic_pkg::ADDR_SUMMARY : 8'h20),
        32'hFFFF_FFFF, resp);
      check({30'h0, resp}, {30'h0, dic_pkg::RESP_SLVERR});
    end
    axi_read(8'h20, rd, resp);
    check({rd[29:0], resp}, {30'h0, dic_pkg::RESP_SLVERR});
    axi_read(dic_pkg::ADDR_RAW_LEVELS, rd, resp);
    check(rd, {26'h0, level});
    axi_read(dic_pkg::ADDR_SUMMARY, rd, resp);
    check(rd, e);
    // bouncing pins: the summary may only move once per sample period
    set_cfg(2, 0);
    chatter <= 1'b1;
    gap = SC;
    ok = 1'b1;
    prev = summary;
    repeat (10 * SC)
    begin
      @(negedge aclk);
      gap++;
      if (summary !== prev)
      begin
        if (gap < SC) ok = 1'b0;
        gap = 0;
        prev = summary;
      end
    end
    check({31'h0, ok}, 32'h1);
    @(posedge aclk);
    chatter <= 1'b0;
    wrap_up();
  end
endmodule

`default_nettype wire
